/* File: rtl/sps_pkg.sv */
// constants, types and register map of the pulse sequencer
// assumes a 100 MHz clock and a plain register port with byte addresses
package sps_pkg;

  // sizes
  localparam int CH_N = 2;
  localparam int SEG_N = 8;
  localparam int SEG_IW = 3;

  // timing: one segment tick is 10 ns, least segment 20 ns
  localparam int CLK_PERIOD_NS = 10;
  localparam int SEG_GRAN_NS = 10;
  localparam int SEG_MIN_NS = 20;
  localparam int TICK_CYC = (SEG_GRAN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SEG_MIN_TICKS = SEG_MIN_NS / SEG_GRAN_NS;
  localparam int TAIL_CYC = TICK_CYC;

  // card register offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CMD = 8'h04;
  localparam logic [7:0] ADDR_PERIOD = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  // channel register window
  localparam int CH_BASE = 'h40;
  localparam int CH_STRIDE = 'h40;
  localparam logic [7:0] OFF_CFG = 8'h00;
  localparam logic [7:0] OFF_HIGH = 8'h04;
  localparam logic [7:0] OFF_LOW = 8'h08;
  localparam logic [7:0] OFF_WIDTH = 8'h0c;
  localparam logic [7:0] OFF_COUNT = 8'h10;
  localparam logic [7:0] OFF_SEQ = 8'h14;
  localparam logic [7:0] OFF_SEG_IDX = 8'h18;
  localparam logic [7:0] OFF_SEG_LV = 8'h1c;
  localparam logic [7:0] OFF_SEG_TM = 8'h20;

  // field positions
  localparam int CTRL_WAVE_LSB = 0;
  localparam int CTRL_SRC_LSB = 2;
  localparam int CTRL_BURST = 4;
  localparam int CTRL_POL = 5;
  localparam int CTRL_IMM = 6;
  localparam int CTRL_MASTER = 7;
  localparam int CMD_ON = 0;
  localparam int CMD_OFF = 1;
  localparam int CMD_APPLY = 2;
  localparam int CMD_RESET = 3;
  localparam int CFG_EN = 0;
  localparam int CFG_COMP = 1;
  localparam int CFG_DC = 2;
  localparam int CFG_SEGL_LSB = 4;
  localparam int TM_TRIG = 16;
  localparam int TM_RELAY = 17;
  localparam int SEQ_ENT_W = 6;
  localparam int SEQ_NUM_LSB = 24;
  localparam int STAT_ST_LSB = 2;
  localparam int STAT_FIN_LSB = 6;
  localparam int STAT_TRIG = 8;

  // modes
  typedef enum logic [1:0] {WAVE_PULSE = 2'h0, WAVE_SEG = 2'h1, WAVE_SEQ = 2'h2} sps_wave_e;
  typedef enum logic [1:0] {
    SRC_PP_RISE = 2'h0, SRC_PP_FALL = 2'h1, SRC_INIT_RISE = 2'h2, SRC_INIT_FALL = 2'h3
  } sps_src_e;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0, ST_ARMED = 2'h1, ST_RUN = 2'h3, ST_TAIL = 2'h2
  } sps_state_e;

  typedef struct packed {
    sps_wave_e wave;
    sps_src_e src;
    logic burst;
    logic pol_neg;
    logic imm;
    logic master;
    logic [31:0] period;
  } sps_card_s;

  typedef struct packed {
    logic en;
    logic comp;
    logic dc;
    logic [SEG_IW-1:0] seg_last;
    logic [15:0] high;
    logic [15:0] low;
    logic [31:0] width;
    logic [15:0] count;
    logic [25:0] seq;
  } sps_chan_s;

  typedef struct packed {
    logic relay;
    logic trig;
    logic [15:0] ticks;
    logic [15:0] stop;
    logic [15:0] start;
  } sps_seg_s;

  typedef struct packed {
    logic on;
    logic relay;
    logic [15:0] level;
  } sps_drive_s;

  // defaults, levels in millivolts, times in 10 ns ticks
  localparam logic [15:0] DEF_HIGH = 16'h03e8;
  localparam logic [15:0] DEF_LOW = 16'h0000;
  localparam logic [31:0] DEF_PERIOD = 32'h0000_03e8;
  localparam logic [31:0] DEF_WIDTH = 32'h0000_01f4;
  localparam logic [15:0] DEF_COUNT = 16'h0001;
  localparam sps_card_s CARD_DEF = '{WAVE_PULSE, SRC_PP_RISE, 1'b0, 1'b0, 1'b0, 1'b0, DEF_PERIOD};
  localparam sps_chan_s CHAN_DEF = '{1'b0, 1'b0, 1'b0, 3'h0, DEF_HIGH, DEF_LOW, DEF_WIDTH,
                                     DEF_COUNT, 26'h0};
  localparam sps_seg_s SEG_DEF = '{1'b0, 1'b0, 16'h0002, 16'h0000, 16'h0000};

endpackage : sps_pkg

/* File: rtl/sps_trig.sv */
// trigger pin synchroniser and edge qualifier
// assumes the pin is asynchronous to mclk_i
module sps_trig
  import sps_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  // pin and edge selection
  input wire logic pin_i,
  input wire logic fall_i,
  // qualified edge, one cycle
  output logic edge_o
);

  logic sync1;
  logic sync2;
  logic prev;

  ////////////////////////////////////////////////////////////////////////////
  // two-flop synchroniser plus history flop
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      prev <= 1'b0;
    end else if (ce_i) begin
      sync1 <= pin_i;
      sync2 <= sync1;
      prev <= sync2;
    end
  end

  // rising or falling edge as selected
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      edge_o <= 1'b0;
    end else if (ce_i) begin
      edge_o <= fall_i ? (prev & ~sync2) : (~prev & sync2); // R7
    end
  end

endmodule : sps_trig

/* File: rtl/sps_top.sv */
// two-channel pulse and segment sequence controller with register port
// assumes one 100 MHz clock, synchronous reset and an asynchronous trigger pin
// Notes on behaviour
// R1: complement swaps high and low levels
// R2: DC mode holds the high level
// R3: defaults are 1 V high, 0 V low
// R4: pulse count used only in burst
// R5: only enabled channels drive
// R6: output on and off act on all channels
// R7: four trigger source edge types
// R8: continuous or burst output mode
// R9: pulse period sets standard pulse repetition
// R10: trigger polarity positive or negative
// R11: immediate apply or explicit apply command
// R12: reset all restores pulse mode defaults
// R13: extra 10 ns tail holds last values
// R14: first start equals last stop (host)
// R15: segment stop equals next start (host)
// R16: segments timed in 10 ns, least 20
// R17: segment trigger bit drives trigger output
// R18: segment relay bit drives output relay
// R19: sequence list plays in listed order
// R20: master card drives trigger output
// R21: master edge matches polarity (host)
// R22: polarity change may look like trigger
// R23: burst stops after count, continuous repeats
// R24: initial edge starts run, per-pulse one pulse
module sps_top
  import sps_pkg::*;
(
  // clock, reset, enable
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // trigger pins
  input wire logic trig_i,
  output logic trig_o,
  output logic trig_oe_o,
  // channel outputs
  output sps_drive_s [CH_N-1:0] drive_o
);

  sps_card_s card_stg;
  sps_card_s card_act;
  logic out_on;
  logic trig_edge;
  logic trig_fall;
  logic cmd_wr;
  logic cmd_reset;
  logic cmd_apply;
  logic load_act;
  logic [31:0] rd_mux;
  logic [31:0] ch_rdata [CH_N];
  logic [1:0] ch_state [CH_N];
  logic ch_fin [CH_N];
  logic ch_trig [CH_N];

  ////////////////////////////////////////////////////////////////////////////
  // commands
  assign cmd_wr = reg_wr_i && (reg_addr_i == ADDR_CMD);
  assign cmd_reset = cmd_wr && reg_wdata_i[CMD_RESET];
  assign cmd_apply = cmd_wr && reg_wdata_i[CMD_APPLY];
  // staged settings reach the engine on apply, or live while on with imm set
  assign load_act = cmd_apply || (card_stg.imm && out_on); // R11

  // global output switch, off wins over on
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      out_on <= 1'b0;
    end else if (ce_i && cmd_wr) begin
      if (reg_wdata_i[CMD_OFF]) begin
        out_on <= 1'b0; // R6
      end else if (reg_wdata_i[CMD_ON]) begin
        out_on <= 1'b1; // R6
      end
    end
  end

  // card staged settings
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      card_stg <= CARD_DEF;
    end else if (ce_i) begin
      if (cmd_reset) begin
        card_stg <= CARD_DEF; // R12
      end else if (reg_wr_i && reg_addr_i == ADDR_CTRL) begin
        card_stg.wave <= sps_wave_e'(reg_wdata_i[CTRL_WAVE_LSB +: 2]);
        card_stg.src <= sps_src_e'(reg_wdata_i[CTRL_SRC_LSB +: 2]); // R7
        card_stg.burst <= reg_wdata_i[CTRL_BURST]; // R8
        card_stg.pol_neg <= reg_wdata_i[CTRL_POL]; // R10
        card_stg.imm <= reg_wdata_i[CTRL_IMM];
        card_stg.master <= reg_wdata_i[CTRL_MASTER];
      end else if (reg_wr_i && reg_addr_i == ADDR_PERIOD) begin
        card_stg.period <= reg_wdata_i; // R9
      end
    end
  end

  // card active settings
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      card_act <= CARD_DEF;
    end else if (ce_i) begin
      if (cmd_reset) begin
        card_act <= CARD_DEF; // R12
      end else if (load_act) begin
        card_act <= card_stg; // R11
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // trigger input
  assign trig_fall = (card_act.src == SRC_PP_FALL) || (card_act.src == SRC_INIT_FALL);

  sps_trig u_trig (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .pin_i(trig_i),
    .fall_i(trig_fall),
    .edge_o(trig_edge)
  );

  // master drives the trigger line, negative polarity inverts it
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      trig_o <= 1'b0;
      trig_oe_o <= 1'b0;
    end else if (ce_i) begin
      trig_oe_o <= card_act.master; // R20
      trig_o <= card_act.master & (ch_trig[0] ^ card_act.pol_neg); // R20 R10
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-channel settings, segment store and engine
  for (genvar c = 0; c < CH_N; c++) begin : g_ch
    localparam logic [7:0] BASE = 8'(CH_BASE + c * CH_STRIDE);
    sps_chan_s stg;
    sps_chan_s act;
    sps_seg_s mem [SEG_N];
    logic [SEG_IW-1:0] idx;
    sps_state_e state;
    logic [31:0] cnt;
    logic [SEG_IW-1:0] seg;
    logic [1:0] ent;
    logic [15:0] left;
    logic fin;
    logic [5:0] cur_ent;
    logic [SEG_IW-1:0] cur_last;
    logic [SEG_IW-1:0] first0;
    logic [SEG_IW-1:0] next_first;
    logic last_ent;
    logic pulse_mode;
    logic per_pulse;
    logic [15:0] ticks;
    logic [31:0] step_len;
    logic step_end;
    logic rep_end;
    logic phase;
    logic [15:0] hi_lvl;
    logic [15:0] lo_lvl;
    logic [31:0] rd;

    // staged channel settings and segment index
    always_ff @(posedge mclk_i) begin
      if (reset_i) begin
        stg <= CHAN_DEF;
        idx <= '0;
      end else if (ce_i) begin
        if (cmd_reset) begin
          stg <= CHAN_DEF; // R3 R12
          idx <= '0;
        end else if (reg_wr_i) begin
          unique case (reg_addr_i)
            BASE + OFF_CFG: begin
              stg.en <= reg_wdata_i[CFG_EN];
              stg.comp <= reg_wdata_i[CFG_COMP];
              stg.dc <= reg_wdata_i[CFG_DC];
              stg.seg_last <= reg_wdata_i[CFG_SEGL_LSB +: SEG_IW];
            end
            BASE + OFF_HIGH: stg.high <= reg_wdata_i[15:0];
            BASE + OFF_LOW: stg.low <= reg_wdata_i[15:0];
            BASE + OFF_WIDTH: stg.width <= reg_wdata_i;
            BASE + OFF_COUNT: stg.count <= reg_wdata_i[15:0];
            BASE + OFF_SEQ: stg.seq <= reg_wdata_i[25:0];
            BASE + OFF_SEG_IDX: idx <= reg_wdata_i[SEG_IW-1:0];
            default: ;
          endcase
        end
      end
    end

    // segment store, one entry per index
    always_ff @(posedge mclk_i) begin
      if (reset_i || (ce_i && cmd_reset)) begin
        for (int s = 0; s < SEG_N; s++) begin
          mem[s] <= SEG_DEF;
        end
      end else if (ce_i && reg_wr_i) begin
        if (reg_addr_i == BASE + OFF_SEG_LV) begin
          mem[idx].start <= reg_wdata_i[15:0];
          mem[idx].stop <= reg_wdata_i[31:16];
        end else if (reg_addr_i == BASE + OFF_SEG_TM) begin
          mem[idx].ticks <= reg_wdata_i[15:0];
          mem[idx].trig <= reg_wdata_i[TM_TRIG]; // R17
          mem[idx].relay <= reg_wdata_i[TM_RELAY]; // R18
        end
      end
    end

    // active channel settings
    always_ff @(posedge mclk_i) begin
      if (reset_i) begin
        act <= CHAN_DEF;
      end else if (ce_i) begin
        if (cmd_reset) begin
          act <= CHAN_DEF; // R12
        end else if (load_act) begin
          act <= stg; // R11
        end
      end
    end

    // waveform bounds and step timing
    always_comb begin
      pulse_mode = (card_act.wave == WAVE_PULSE);
      per_pulse = (card_act.src == SRC_PP_RISE) || (card_act.src == SRC_PP_FALL); // R24
      cur_ent = act.seq[ent * SEQ_ENT_W +: SEQ_ENT_W];
      first0 = act.seq[SEG_IW-1:0];
      next_first = act.seq[2'(ent + 2'h1) * SEQ_ENT_W +: SEG_IW];
      if (card_act.wave == WAVE_SEQ) begin
        cur_last = cur_ent[2 * SEG_IW - 1:SEG_IW]; // R19
        last_ent = (ent == act.seq[SEQ_NUM_LSB +: 2]);
      end else begin
        cur_last = act.seg_last;
        last_ent = 1'b1;
        first0 = '0;
      end
      ticks = (mem[seg].ticks < 16'(SEG_MIN_TICKS)) ? 16'(SEG_MIN_TICKS) : mem[seg].ticks;
      if (pulse_mode) begin
        step_len = 32'(card_act.period * TICK_CYC); // R9
      end else begin
        step_len = 32'(ticks * TICK_CYC); // R16
      end
      step_end = (cnt >= step_len - 32'h1);
      rep_end = ((state == ST_RUN) && pulse_mode && step_end)
                || ((state == ST_TAIL) && (cnt >= 32'(TAIL_CYC - 1)));
      phase = (cnt < 32'(act.width * TICK_CYC));
    end

    // sequencing engine
    always_ff @(posedge mclk_i) begin
      if (reset_i) begin
        state <= ST_IDLE;
        cnt <= '0;
        seg <= '0;
        ent <= '0;
        left <= '0;
        fin <= 1'b0;
      end else if (ce_i) begin
        if (!out_on || !act.en) begin
          state <= ST_IDLE; // R5 R6
          cnt <= '0;
          fin <= fin & out_on;
        end else if (rep_end) begin
          cnt <= '0;
          ent <= '0;
          seg <= first0;
          if (card_act.burst && left <= 16'h1) begin
            state <= ST_IDLE; // R23 R4
            fin <= 1'b1;
          end else begin
            if (card_act.burst) begin
              left <= left - 16'h1; // R4
            end
            state <= per_pulse ? ST_ARMED : ST_RUN; // R24 R8
          end
        end else begin
          unique case (state)
            ST_IDLE: begin
              if (!fin) begin
                state <= ST_ARMED;
                left <= act.count;
              end
            end
            ST_ARMED: begin
              if (trig_edge) begin
                state <= ST_RUN; // R24
                cnt <= '0;
                ent <= '0;
                seg <= first0;
              end
            end
            ST_RUN: begin
              if (!step_end) begin
                cnt <= cnt + 32'h1;
              end else begin
                cnt <= '0;
                if (seg != cur_last) begin
                  seg <= seg + 1'b1;
                end else if (last_ent) begin
                  state <= ST_TAIL; // R13
                end else begin
                  ent <= ent + 2'h1; // R19
                  seg <= next_first;
                end
              end
            end
            ST_TAIL: cnt <= cnt + 32'h1; // R13
          endcase
        end
      end
    end

    // output level, relay and trigger level
    assign hi_lvl = act.comp ? act.low : act.high; // R1
    assign lo_lvl = act.comp ? act.high : act.low; // R1

    always_ff @(posedge mclk_i) begin
      if (reset_i) begin
        drive_o[c] <= '0;
        ch_trig[c] <= 1'b0;
      end else if (ce_i) begin
        drive_o[c].on <= out_on && act.en; // R5 R6
        if (act.dc) begin
          drive_o[c].level <= act.high; // R2
          drive_o[c].relay <= 1'b1;
          ch_trig[c] <= 1'b0;
        end else if (state == ST_RUN && pulse_mode) begin
          drive_o[c].level <= phase ? hi_lvl : lo_lvl;
          drive_o[c].relay <= 1'b1;
          ch_trig[c] <= phase;
        end else if ((state == ST_RUN || state == ST_TAIL) && !pulse_mode) begin
          drive_o[c].level <= (state == ST_TAIL || step_end) ? mem[seg].stop
                              : mem[seg].start; // R13
          drive_o[c].relay <= mem[seg].relay; // R18
          ch_trig[c] <= mem[seg].trig; // R17 R13
        end else begin
          drive_o[c].level <= pulse_mode ? lo_lvl : mem[first0].start;
          drive_o[c].relay <= pulse_mode;
          ch_trig[c] <= 1'b0;
        end
      end
    end

    // register readback of this channel
    always_comb begin
      rd = '0;
      if (reg_addr_i == BASE + OFF_CFG) begin
        rd[CFG_EN] = stg.en;
        rd[CFG_COMP] = stg.comp;
        rd[CFG_DC] = stg.dc;
        rd[CFG_SEGL_LSB +: SEG_IW] = stg.seg_last;
      end else if (reg_addr_i == BASE + OFF_HIGH) begin
        rd[15:0] = stg.high;
      end else if (reg_addr_i == BASE + OFF_LOW) begin
        rd[15:0] = stg.low;
      end else if (reg_addr_i == BASE + OFF_WIDTH) begin
        rd = stg.width;
      end else if (reg_addr_i == BASE + OFF_COUNT) begin
        rd[15:0] = stg.count;
      end else if (reg_addr_i == BASE + OFF_SEQ) begin
        rd[25:0] = stg.seq;
      end else if (reg_addr_i == BASE + OFF_SEG_IDX) begin
        rd[SEG_IW-1:0] = idx;
      end else if (reg_addr_i == BASE + OFF_SEG_LV) begin
        rd = {mem[idx].stop, mem[idx].start};
      end else if (reg_addr_i == BASE + OFF_SEG_TM) begin
        rd[15:0] = mem[idx].ticks;
        rd[TM_TRIG] = mem[idx].trig;
        rd[TM_RELAY] = mem[idx].relay;
      end
    end

    assign ch_rdata[c] = rd;
    assign ch_state[c] = state;
    assign ch_fin[c] = fin;
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux, unmapped addresses read zero
  always_comb begin
    rd_mux = '0;
    if (reg_addr_i == ADDR_CTRL) begin
      rd_mux[CTRL_WAVE_LSB +: 2] = card_stg.wave;
      rd_mux[CTRL_SRC_LSB +: 2] = card_stg.src;
      rd_mux[CTRL_BURST] = card_stg.burst;
      rd_mux[CTRL_POL] = card_stg.pol_neg;
      rd_mux[CTRL_IMM] = card_stg.imm;
      rd_mux[CTRL_MASTER] = card_stg.master;
    end else if (reg_addr_i == ADDR_PERIOD) begin
      rd_mux = card_stg.period;
    end else if (reg_addr_i == ADDR_STATUS) begin
      rd_mux[0] = out_on;
      rd_mux[STAT_TRIG] = trig_o;
      for (int c = 0; c < CH_N; c++) begin
        rd_mux[STAT_ST_LSB + 2 * c +: 2] = ch_state[c];
        rd_mux[STAT_FIN_LSB + c] = ch_fin[c];
      end
    end else begin
      for (int c = 0; c < CH_N; c++) begin
        rd_mux = rd_mux | ch_rdata[c];
      end
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      reg_rdata_o <= '0;
    end else if (ce_i) begin
      reg_rdata_o <= reg_rd_i ? rd_mux : 32'h0;
    end
  end

endmodule : sps_top

/* File: verification/sps_props.sv */
// port checker for the pulse sequencer top
// assumes a bind from the bench and a clock enable held high
module sps_props
  import sps_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  // trigger pins
  input wire logic trig_i,
  input wire logic trig_o,
  input wire logic trig_oe_o,
  // channel outputs
  input wire sps_drive_s [CH_N-1:0] drive_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  ////////////////////////////////////////////////////////////////////////////////
  // command write decode
  wire logic cmd_w = reg_wr_i && reg_addr_i == ADDR_CMD;
  ////////////////////////////////////////////////////////////////////////////////
  // register port answers
  a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
    else $error("read data outside read slot");
  a_cmd_read: assert property (reg_rd_i && reg_addr_i == ADDR_CMD |=> reg_rdata_o == 32'h0)
    else $error("command register read not zero");
  // output on and off
  a_off_all: assert property (cmd_w && reg_wdata_i[CMD_OFF] |->
    ##2 (!drive_o[0].on && !drive_o[1].on))
    else $error("output off missed a channel");
  a_on_cause0: assert property ($rose(drive_o[0].on) |-> $past(reg_wr_i, 2))
    else $error("channel 0 on without a write");
  a_on_cause1: assert property ($rose(drive_o[1].on) |-> $past(reg_wr_i, 2))
    else $error("channel 1 on without a write");
  a_reset_off: assert property (cmd_w && reg_wdata_i[CMD_RESET] |->
    ##[1:3] (!drive_o[0].on && !drive_o[1].on))
    else $error("reset all left a channel on");
  // trigger output
  a_oe_cause: assert property ($changed(trig_oe_o) |-> $past(reg_wr_i) || $past(reg_wr_i, 2))
    else $error("trigger enable moved without a write");
  a_trig_quiet: assert property (!trig_oe_o |-> !trig_o)
    else $error("trigger output high while not master");
  // main scenarios
  c_on: cover property ($rose(drive_o[0].on));
  c_master: cover property (trig_oe_o && trig_o);
  c_relay: cover property (drive_o[0].relay ##1 !drive_o[0].relay);
endmodule : sps_props

/* File: verification/sps_src.sv */
// trigger source model driving the card trigger pin
// assumes go_i is a one-cycle request from the bench
module sps_src (
  // clock
  input wire logic mclk_i,
  // request
  input wire logic go_i,
  // trigger pin
  output logic pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] left = 2'h0;
  // three-cycle pulse, pin driven low between pulses
  always @(posedge mclk_i) begin
    if (go_i) begin
      left <= 2'h3;
    end else if (left != 2'h0) begin
      left <= left - 2'h1;
    end
  end
  assign pin_o = left != 2'h0;
endmodule : sps_src

/* File: verification/tb_sps_top.sv */
// bench for the pulse sequencer: register tasks and a scenario sequence
// assumes the trigger source model and the port checker bound below
module tb_sps_top
  import sps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] C0 = 8'(CH_BASE);
  localparam logic [7:0] C1 = 8'(CH_BASE + CH_STRIDE);
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic ce_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic go = 1'b0;
  logic [31:0] reg_rdata_o, rv;
  logic trig_i, trig_o, trig_oe_o;
  sps_drive_s [CH_N-1:0] drive_o;
  int fails = 0;
  int compares = 0;
  int n;

  initial forever #5 mclk_i = ~mclk_i;

  sps_top i_dut (.mclk_i, .reset_i, .ce_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .trig_i, .trig_o, .trig_oe_o, .drive_o);
  sps_src i_src (.mclk_i, .go_i(go), .pin_o(trig_i));
  ////////////////////////////////////////////////////////////////////////////////
  // compare and close
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic end_sim();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim
  // register cycles, a gap cycle after each
  task automatic wr(logic [7:0] a, logic [31:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
    @(posedge mclk_i);
  endtask : wr
  task automatic rd(logic [7:0] a, output logic [31:0] d);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    @(posedge mclk_i);
    d = reg_rdata_o;
  endtask : rd
  // one trigger pulse from the source model
  task automatic fire();
    go <= 1'b1;
    @(posedge mclk_i);
    go <= 1'b0;
    repeat (4) @(posedge mclk_i);
  endtask : fire
  // conditions: 0 level match, 1 trigger out, 2 relay closed
  function automatic logic cond(int k, logic [15:0] lv);
    case (k)
      0: return drive_o[0].level === lv;
      1: return trig_o === 1'b1;
      default: return drive_o[0].relay === 1'b1;
    endcase
  endfunction : cond
  task automatic wt(int k, logic [15:0] lv);
    int i;
    for (i = 0; i < 300 && !cond(k, lv); i++) @(posedge mclk_i);
    if (i == 300) begin
      chk("wait bound", 32'h1, 32'h0);
      end_sim();
    end
  endtask : wt
  task automatic dur(int k, logic [15:0] lv, output int c);
    for (c = 0; c < 40 && cond(k, lv); c++) @(posedge mclk_i);
  endtask : dur
  task automatic rises(int cyc, logic [15:0] lv, output int c);
    logic was;
    c = 0;
    was = cond(0, lv);
    repeat (cyc) begin
      @(posedge mclk_i);
      if (cond(0, lv) && !was) c++;
      was = cond(0, lv);
    end
  endtask : rises
  ////////////////////////////////////////////////////////////////////////////////
  // scenario sequence
  initial begin
    repeat (20) @(posedge mclk_i);
    reset_i <= 1'b0;
    @(posedge mclk_i);
    rd(C0 + OFF_HIGH, rv);
    chk("high", rv, 32'h3e8);
    rd(C0 + OFF_LOW, rv);
    chk("low", rv, 32'h0);
    rd(ADDR_PERIOD, rv);
    chk("period", rv, 32'h3e8);
    rd(8'h30, rv);
    chk("unmapped", rv, 32'h0);
    rd(ADDR_CMD, rv);
    chk("cmd", rv, 32'h0);
    // pulse 4 of 10 cycles, a burst of 2 first, then continuous and per pulse
    wr(C0 + OFF_HIGH, 32'h800);
    wr(C0 + OFF_LOW, 32'h100);
    wr(C0 + OFF_WIDTH, 32'h4);
    wr(ADDR_PERIOD, 32'ha);
    wr(C0 + OFF_COUNT, 32'h2);
    wr(C0 + OFF_CFG, 32'h1);
    for (int s = 0; s < 5; s++) begin
      wr(ADDR_CTRL, 32'((s + 2) % 4) << CTRL_SRC_LSB | 32'(s == 0) << CTRL_BURST);
      wr(ADDR_CMD, 32'h6);
      wr(ADDR_CMD, 32'h1);
      @(posedge mclk_i);
      chk("ch0 on", 32'(drive_o[0].on), 32'h1);
      chk("ch1 on", 32'(drive_o[1].on), 32'h0);
      fire();
      rises(100, 16'h800, n);
      chk("pulses", 32'(n), s == 0 ? 32'h2 : s inside {2, 3} ? 32'h1 : 32'ha);
    end
    // complement swaps the phases
    wr(C0 + OFF_CFG, 32'h3);
    wr(ADDR_CMD, 32'h4);
    wt(0, 16'h100);
    wt(0, 16'h800);
    dur(0, 16'h800, n);
    chk("comp high", 32'(n), 32'h6);
    // fixed level, then back to pulses
    wr(C0 + OFF_CFG, 32'h5);
    wr(ADDR_CMD, 32'h4);
    dur(0, 16'h800, n);
    chk("dc hold", 32'(n), 32'd40);
    chk("dc relay", 32'(drive_o[0].relay), 32'h1);
    wr(C0 + OFF_CFG, 32'h1);
    wr(ADDR_CMD, 32'h4);
    wt(0, 16'h100);
    // immediate apply, then staged
    wr(ADDR_CTRL, 32'h4c);
    wr(ADDR_CMD, 32'h4);
    wr(C0 + OFF_CFG, 32'h5);
    wr(C0 + OFF_HIGH, 32'h900);
    wt(0, 16'h900);
    wr(ADDR_CTRL, 32'hc);
    wr(ADDR_CMD, 32'h4);
    wr(C0 + OFF_HIGH, 32'ha00);
    repeat (8) @(posedge mclk_i);
    chk("staged", 32'(drive_o[0].level), 32'h900);
    wr(ADDR_CMD, 32'h4);
    wt(0, 16'ha00);
    // off reaches every channel
    wr(C1 + OFF_CFG, 32'h1);
    wr(ADDR_CMD, 32'h4);
    @(posedge mclk_i);
    chk("ch1 on", 32'(drive_o[1].on), 32'h1);
    wr(ADDR_CMD, 32'h2);
    @(posedge mclk_i);
    chk("all off", 32'({drive_o[1].on, drive_o[0].on}), 32'h0);
    // polarity changed only while outputs are off
    wr(ADDR_CTRL, 32'h20);
    rd(ADDR_CTRL, rv);
    chk("polarity", rv, 32'h20);
    wr(ADDR_CMD, 32'h8);
    rd(ADDR_CTRL, rv);
    chk("ctrl def", rv, 32'h0);
    rd(C0 + OFF_HIGH, rv);
    chk("high def", rv, 32'h3e8);
    // two segments, levels joined end to end
    wr(C0 + OFF_SEG_IDX, 32'h0);
    wr(C0 + OFF_SEG_LV, 32'h0200_0100);
    wr(C0 + OFF_SEG_TM, 32'h2_0003);
    wr(C0 + OFF_SEG_IDX, 32'h1);
    wr(C0 + OFF_SEG_LV, 32'h0100_0200);
    wr(C0 + OFF_SEG_TM, 32'h1_0002);
    wr(C0 + OFF_CFG, 32'h11);
    wr(ADDR_CTRL, 32'h99);
    wr(ADDR_CMD, 32'h4);
    wr(ADDR_CMD, 32'h1);
    chk("master", 32'(trig_oe_o), 32'h1);
    fire();
    wt(2, 16'h0);
    dur(2, 16'h0, n);
    chk("seg0 relay", 32'(n), 32'h3);
    @(posedge mclk_i);
    chk("seg1 trig", 32'(trig_o), 32'h1);
    dur(1, 16'h0, n);
    chk("seg1 tail", 32'(n), 32'h3);
    // two-entry list: second segment plays first, then the first one
    wr(C0 + OFF_SEQ, 32'h0100_0009);
    wr(ADDR_CTRL, 32'h9a);
    wr(ADDR_CMD, 32'h6);
    wr(ADDR_CMD, 32'h1);
    fire();
    wt(1, 16'h0);
    chk("seq first", 32'(drive_o[0].relay), 32'h0);
    wt(2, 16'h0);
    dur(2, 16'h0, n);
    chk("seq last", 32'(n), 32'h4);
    end_sim();
  end
endmodule : tb_sps_top

bind sps_top sps_props i_props (.mclk_i, .reset_i, .ce_i, .reg_addr_i, .reg_wdata_i,
  .reg_wr_i, .reg_rd_i, .reg_rdata_o, .trig_i, .trig_o, .trig_oe_o, .drive_o);
